// ==== rtl/pecr_pkg.sv ====
// constants, codes and register map for the port enable / recovery command handler
// How it works
// [RULE1] set-enable request answered with code 0x31,0x32, flag and a 34-byte port data block
// [RULE2] first reply data byte: 0x30 ok, 0x31 not in setting mode, 0x39 failed
// [RULE3] reference byte: 0x30 supply (default), 0x31 internal 2.56V, 0x32 external
// [RULE4] field groups separated by one comma byte 0x2C at fixed positions
// [RULE5] port enable bytes: 0x31 enabled, 0x32 disabled, at fixed byte positions
// [RULE6] host queries enables with code 0x31,0x33 plus one dummy byte 0x30
// [RULE7] enable query answered with set-reply code and layout, flag always 0x30
// [RULE8] after reset every port enabled and every analog input in level mode
// [RULE9] host sets recovery with code 0x31,0x34 plus 12 data bytes with commas
// [RULE10] recovery set answered with code 0x31,0x35, flag and 12 shifted layout bytes
// [RULE11] recovery query 0x31,0x36 plus dummy; reply uses recovery layout, flag 0x30
// [RULE12] after reset power-loss recovery enabled on all outputs
// [RULE13] analog mode byte: 0x31 level input, 0x32 switch input
// [RULE14] refused or failed setting leaves stored values unchanged, reports current ones
// [RULE15] unknown code or wrong data length discarded without touching settings
package pecr_pkg;
	localparam logic [7:0] CODE_HI = 8'h31;
	localparam logic [7:0] CODE_ENA_SET = 8'h31;
	localparam logic [7:0] CODE_ENA_RSP = 8'h32;
	localparam logic [7:0] CODE_ENA_QRY = 8'h33;
	localparam logic [7:0] CODE_REC_SET = 8'h34;
	localparam logic [7:0] CODE_REC_RSP = 8'h35;
	localparam logic [7:0] CODE_REC_QRY = 8'h36;
	localparam logic [5:0] LEN_ENA_SET = 6'h22;
	localparam logic [5:0] LEN_REC_SET = 6'h0C;
	localparam logic [5:0] LEN_QRY = 6'h01;
	localparam logic [5:0] LEN_ENA_RSP = 6'h25;
	localparam logic [5:0] LEN_REC_RSP = 6'h0F;
	localparam logic [7:0] FLAG_OK = 8'h30;
	localparam logic [7:0] FLAG_NOT_SET = 8'h31;
	localparam logic [7:0] FLAG_SETTING_FAILED = 8'h39;
	localparam logic [7:0] BYTE_SEP = 8'h2C;
	localparam logic [7:0] BYTE_ON = 8'h31;
	localparam logic [7:0] BYTE_OFF = 8'h32;
	localparam logic [7:0] BYTE_REF0 = 8'h30;
	localparam logic [7:0] BYTE_REF_MAX = 8'h32;
	localparam logic [2:0] K_SEP = 3'h0;
	localparam logic [2:0] K_ADC = 3'h1;
	localparam logic [2:0] K_REF = 3'h2;
	localparam logic [2:0] K_IN = 3'h3;
	localparam logic [2:0] K_OUT = 3'h4;
	localparam logic [2:0] K_REC = 3'h5;
	localparam logic [4:0] NUM_IN = 5'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INT_STAT = 8'h04;
	localparam logic [7:0] ADDR_INT_MASK = 8'h08;
	localparam logic [7:0] ADDR_PORT_EN = 8'h0C;
	localparam logic [7:0] ADDR_ADC_CFG = 8'h10;
	localparam logic [7:0] ADDR_REC_EN = 8'h14;
	localparam logic [7:0] ADDR_STATE = 8'h18;
	localparam logic RST_SET_MODE = 1'b1;
	localparam logic [2:0] RST_INT_MASK = 3'h0;
	localparam logic [11:0] RST_IN_EN = 12'hFFF;
	localparam logic [9:0] RST_OUT_EN = 10'h3FF;
	localparam logic [9:0] RST_REC_EN = 10'h3FF;
	localparam logic [3:0] RST_ADC_SW = 4'h0;
	localparam logic [1:0] RST_ADC_REF = 2'h0;
	typedef enum logic [2:0] {
		ST_CODE0 = 3'b000,
		ST_CODE1 = 3'b001,
		ST_DATA = 3'b010,
		ST_DROP = 3'b011,
		ST_REPLY = 3'b100
	} pecr_state_e;
endpackage : pecr_pkg

// ==== rtl/pecr_top.sv ====
// command interpreter for port enable and power-loss recovery settings
`timescale 1ns/100ps
module pecr_top (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// received command bytes
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_last,
	output logic o_rx_ready,
	// reply bytes
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	// stored settings and interrupt
	output logic [11:0] o_in_en,
	output logic [9:0] o_out_en,
	output logic [9:0] o_rec_en,
	output logic [3:0] o_adc_switch,
	output logic [1:0] o_adc_ref,
	output logic o_irq
);
	import pecr_pkg::*;

	// maps a layout position (1-based) to field kind and port index
	function automatic logic [7:0] lay_pos(input logic [5:0] p, input logic is_rec);
		logic [5:0] q;
		logic [2:0] g;
		logic [2:0] r;
		logic [4:0] n;
		logic [2:0] k;
		logic [4:0] idx;
		q = is_rec ? (p - 6'h01) : (p - 6'h08);
		g = 3'(q / 6'h05);
		r = 3'(q % 6'h05);
		n = 5'({2'h0, g} << 2) + {2'h0, r};
		idx = n;
		if (r == 3'h4) begin
			k = K_SEP; // [RULE4]
		end else if (is_rec) begin
			k = K_REC;
		end else if (n < NUM_IN) begin
			k = K_IN;
		end else begin
			k = K_OUT;
			idx = n - NUM_IN;
		end
		if (!is_rec && p < 6'h05) begin
			k = K_ADC;
			idx = 5'(p - 6'h01);
		end else if (!is_rec && (p == 6'h05 || p == 6'h07)) begin
			k = K_SEP; // [RULE4]
		end else if (!is_rec && p == 6'h06) begin
			k = K_REF;
		end
		return {k, idx};
	endfunction : lay_pos

	pecr_state_e state_r, state_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [7:0] code_r, code_nxt;
	logic err_r, err_nxt;
	logic rec_r, rec_nxt;
	logic [7:0] flag_r, flag_nxt;
	logic [11:0] sh_in_r, sh_in_nxt;
	logic [9:0] sh_out_r, sh_out_nxt;
	logic [9:0] sh_rec_r, sh_rec_nxt;
	logic [3:0] sh_sw_r, sh_sw_nxt;
	logic [1:0] sh_ref_r, sh_ref_nxt;
	logic [11:0] in_en_nxt;
	logic [9:0] out_en_nxt;
	logic [9:0] rec_en_nxt;
	logic [3:0] sw_nxt;
	logic [1:0] ref_nxt;
	logic rx_ready_nxt;
	logic tx_valid_nxt;
	logic [7:0] tx_data_nxt;
	logic ev_cmd, ev_refused, ev_drop;
	logic take;
	logic [5:0] dlen;
	logic [5:0] pos;
	logic [7:0] cls;
	logic byte_ok;
	logic [5:0] rlen;
	logic [7:0] rbyte;
	logic [7:0] rcls;

	// apb side state
	logic set_mode_r, set_mode_nxt;
	logic [2:0] mask_r, mask_nxt;
	logic [2:0] stat_r, stat_nxt;
	logic pready_nxt;
	logic pslverr_nxt;
	logic [31:0] prdata_nxt;
	logic irq_nxt;
	logic apb_done;
	logic map_hit;

	assign take = i_rx_valid && o_rx_ready;
	assign pos = cnt_r + 6'h01;
	assign cls = lay_pos(pos, rec_r);

	always_comb begin
		dlen = LEN_QRY;
		if (code_r == CODE_ENA_SET) begin
			dlen = LEN_ENA_SET;
		end else if (code_r == CODE_REC_SET) begin
			dlen = LEN_REC_SET;
		end
		unique case (cls[7:5])
			K_SEP: byte_ok = (i_rx_data == BYTE_SEP); // [RULE4]
			K_REF: byte_ok = (i_rx_data >= BYTE_REF0) && (i_rx_data <= BYTE_REF_MAX); // [RULE3]
			default: byte_ok = (i_rx_data == BYTE_ON) || (i_rx_data == BYTE_OFF); // [RULE5] [RULE13]
		endcase
	end

	// reply byte at index cnt_r, drawn from the stored settings
	always_comb begin
		rlen = rec_r ? LEN_REC_RSP : LEN_ENA_RSP;
		rcls = lay_pos(cnt_r - 6'h02, rec_r);
		unique case (rcls[7:5])
			K_SEP: rbyte = BYTE_SEP; // [RULE4]
			K_ADC: rbyte = o_adc_switch[rcls[1:0]] ? BYTE_OFF : BYTE_ON; // [RULE13]
			K_REF: rbyte = BYTE_REF0 | {6'h00, o_adc_ref}; // [RULE3]
			K_IN: rbyte = o_in_en[rcls[3:0]] ? BYTE_ON : BYTE_OFF; // [RULE5]
			K_OUT: rbyte = o_out_en[rcls[3:0]] ? BYTE_ON : BYTE_OFF; // [RULE5]
			default: rbyte = o_rec_en[rcls[3:0]] ? BYTE_ON : BYTE_OFF; // [RULE10]
		endcase
		if (cnt_r == 6'h00) begin
			rbyte = CODE_HI;
		end else if (cnt_r == 6'h01) begin
			rbyte = rec_r ? CODE_REC_RSP : CODE_ENA_RSP; // [RULE1] [RULE10]
		end else if (cnt_r == 6'h02) begin
			rbyte = flag_r; // [RULE2]
		end
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		code_nxt = code_r;
		err_nxt = err_r;
		rec_nxt = rec_r;
		flag_nxt = flag_r;
		sh_in_nxt = sh_in_r;
		sh_out_nxt = sh_out_r;
		sh_rec_nxt = sh_rec_r;
		sh_sw_nxt = sh_sw_r;
		sh_ref_nxt = sh_ref_r;
		in_en_nxt = o_in_en;
		out_en_nxt = o_out_en;
		rec_en_nxt = o_rec_en;
		sw_nxt = o_adc_switch;
		ref_nxt = o_adc_ref;
		tx_valid_nxt = o_tx_valid;
		tx_data_nxt = o_tx_data;
		ev_cmd = 1'b0;
		ev_refused = 1'b0;
		ev_drop = 1'b0;
		unique case (state_r)
			ST_CODE0: begin
				if (take) begin
					if (i_rx_last) begin
						ev_drop = 1'b1; // [RULE15]
					end else begin
						state_nxt = (i_rx_data == CODE_HI) ? ST_CODE1 : ST_DROP;
					end
				end
			end
			ST_CODE1: begin
				if (take) begin
					code_nxt = i_rx_data;
					cnt_nxt = 6'h00;
					err_nxt = 1'b0;
					rec_nxt = (i_rx_data == CODE_REC_SET) || (i_rx_data == CODE_REC_QRY);
					if (i_rx_last) begin
						ev_drop = 1'b1; // [RULE15]
						state_nxt = ST_CODE0;
					end else if (i_rx_data == CODE_ENA_SET || i_rx_data == CODE_ENA_QRY
						|| i_rx_data == CODE_REC_SET || i_rx_data == CODE_REC_QRY) begin
						state_nxt = ST_DATA;
					end else begin
						state_nxt = ST_DROP; // [RULE15]
					end
				end
			end
			ST_DATA: begin
				if (take) begin
					if (cnt_r != 6'h3F) begin
						cnt_nxt = pos;
					end
					if (pos <= dlen && (code_r == CODE_ENA_SET || code_r == CODE_REC_SET)) begin
						err_nxt = err_r || !byte_ok; // [RULE4] [RULE5]
						unique case (cls[7:5])
							K_ADC: sh_sw_nxt[cls[1:0]] = (i_rx_data == BYTE_OFF); // [RULE13]
							K_REF: sh_ref_nxt = i_rx_data[1:0]; // [RULE3]
							K_IN: sh_in_nxt[cls[3:0]] = (i_rx_data == BYTE_ON);
							K_OUT: sh_out_nxt[cls[3:0]] = (i_rx_data == BYTE_ON);
							K_REC: sh_rec_nxt[cls[3:0]] = (i_rx_data == BYTE_ON);
							default: sh_ref_nxt = sh_ref_r;
						endcase
					end
					if (i_rx_last) begin
						cnt_nxt = 6'h00;
						if (pos != dlen) begin
							ev_drop = 1'b1; // [RULE15]
							state_nxt = ST_CODE0;
						end else begin
							ev_cmd = 1'b1;
							state_nxt = ST_REPLY;
							flag_nxt = FLAG_OK; // [RULE7] [RULE11]
							if (code_r == CODE_ENA_SET || code_r == CODE_REC_SET) begin
								if (!set_mode_r) begin
									flag_nxt = FLAG_NOT_SET; // [RULE2] [RULE14]
								end else if (err_nxt) begin
									flag_nxt = FLAG_SETTING_FAILED; // [RULE2] [RULE14]
								end else if (rec_r) begin
									rec_en_nxt = sh_rec_nxt; // [RULE10]
								end else begin
									in_en_nxt = sh_in_nxt; // [RULE1]
									out_en_nxt = sh_out_nxt;
									sw_nxt = sh_sw_nxt;
									ref_nxt = sh_ref_nxt;
								end
								ev_refused = !set_mode_r || err_nxt;
							end
						end
					end
				end
			end
			ST_DROP: begin
				if (take && i_rx_last) begin
					ev_drop = 1'b1; // [RULE15]
					state_nxt = ST_CODE0;
				end
			end
			ST_REPLY: begin
				// output byte is held until the sink takes it
				if (!o_tx_valid || i_tx_ready) begin
					if (cnt_r < rlen) begin
						tx_valid_nxt = 1'b1; // [RULE1] [RULE10] [RULE11]
						tx_data_nxt = rbyte;
						cnt_nxt = cnt_r + 6'h01;
					end else begin
						tx_valid_nxt = 1'b0;
						cnt_nxt = 6'h00;
						state_nxt = ST_CODE0;
					end
				end
			end
			default: state_nxt = ST_CODE0;
		endcase
		// receive stalls for the whole reply, so no command overlaps it
		rx_ready_nxt = (state_nxt != ST_REPLY);
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			state_r <= ST_CODE0;
			cnt_r <= 6'h00;
			code_r <= 8'h00;
			err_r <= 1'b0;
			rec_r <= 1'b0;
			flag_r <= FLAG_OK;
			sh_in_r <= RST_IN_EN;
			sh_out_r <= RST_OUT_EN;
			sh_rec_r <= RST_REC_EN;
			sh_sw_r <= RST_ADC_SW;
			sh_ref_r <= RST_ADC_REF;
			o_in_en <= RST_IN_EN; // [RULE8]
			o_out_en <= RST_OUT_EN; // [RULE8]
			o_rec_en <= RST_REC_EN; // [RULE12]
			o_adc_switch <= RST_ADC_SW; // [RULE8]
			o_adc_ref <= RST_ADC_REF; // [RULE3]
			o_rx_ready <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			code_r <= code_nxt;
			err_r <= err_nxt;
			rec_r <= rec_nxt;
			flag_r <= flag_nxt;
			sh_in_r <= sh_in_nxt;
			sh_out_r <= sh_out_nxt;
			sh_rec_r <= sh_rec_nxt;
			sh_sw_r <= sh_sw_nxt;
			sh_ref_r <= sh_ref_nxt;
			o_in_en <= in_en_nxt;
			o_out_en <= out_en_nxt;
			o_rec_en <= rec_en_nxt;
			o_adc_switch <= sw_nxt;
			o_adc_ref <= ref_nxt;
			o_rx_ready <= rx_ready_nxt;
			o_tx_valid <= tx_valid_nxt;
			o_tx_data <= tx_data_nxt;
		end
	end

	// apb: no wait state, pready is high in the first access cycle, data is prepared during setup
	assign apb_done = i_psel && i_penable && o_pready;

	always_comb begin
		set_mode_nxt = set_mode_r;
		mask_nxt = mask_r;
		pready_nxt = i_psel && !i_penable;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		map_hit = 1'b1;
		unique case (i_paddr)
			ADDR_CTRL: prdata_nxt = {31'h0, set_mode_r};
			ADDR_INT_STAT: prdata_nxt = {29'h0, stat_r};
			ADDR_INT_MASK: prdata_nxt = {29'h0, mask_r};
			ADDR_PORT_EN: prdata_nxt = {10'h0, o_out_en, o_in_en};
			ADDR_ADC_CFG: prdata_nxt = {26'h0, o_adc_ref, o_adc_switch};
			ADDR_REC_EN: prdata_nxt = {22'h0, o_rec_en};
			ADDR_STATE: prdata_nxt = {21'h0, flag_r, state_r};
			default: map_hit = 1'b0;
		endcase
		if (i_psel && !i_penable) begin
			pslverr_nxt = !map_hit;
		end else begin
			prdata_nxt = o_prdata;
			pslverr_nxt = o_pslverr && !apb_done;
		end
		if (apb_done && i_pwrite && i_paddr == ADDR_CTRL) begin
			set_mode_nxt = i_pwdata[0];
		end
		if (apb_done && i_pwrite && i_paddr == ADDR_INT_MASK) begin
			mask_nxt = i_pwdata[2:0];
		end
		// read clears, but an event in the same cycle still lands
		stat_nxt = stat_r;
		if (apb_done && !i_pwrite && i_paddr == ADDR_INT_STAT) begin
			stat_nxt = 3'h0;
		end
		stat_nxt = stat_nxt | {ev_drop, ev_refused, ev_cmd};
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			set_mode_r <= RST_SET_MODE;
			mask_r <= RST_INT_MASK;
			stat_r <= 3'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_irq <= 1'b0;
		end else begin
			set_mode_r <= set_mode_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			o_pready <= pready_nxt;
			o_pslverr <= pslverr_nxt;
			o_prdata <= prdata_nxt;
			o_irq <= irq_nxt;
		end
	end
endmodule : pecr_top

// ==== tb/pecr_chk.sv ====
// assertions on the command handler ports
`timescale 1ns/100ps
module pecr_chk (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// byte streams
	input wire logic i_rx_valid,
	input wire logic i_rx_last,
	input wire logic o_rx_ready,
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	// settings
	input wire logic [11:0] o_in_en,
	input wire logic [9:0] o_out_en,
	input wire logic [9:0] o_rec_en,
	input wire logic [3:0] o_adc_switch,
	input wire logic [1:0] o_adc_ref
);
	wire logic last_take = i_rx_valid & o_rx_ready & i_rx_last;
	wire logic [37:0] set_w = {o_in_en, o_out_en, o_rec_en, o_adc_switch, o_adc_ref};
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	a_reset_ports: assert property (disable iff (1'b0)
		!i_rstn |=> o_in_en == 12'hFFF && o_out_en == 10'h3FF && o_adc_switch == 4'h0)
		else $error("ports not at defaults after reset");
	a_reset_rec: assert property (disable iff (1'b0) !i_rstn |=> o_rec_en == 10'h3FF)
		else $error("recovery not enabled after reset");
	a_ref_legal: assert property (o_adc_ref != 2'h3)
		else $error("reference code out of range");
	a_reply_lead: assert property ($rose(o_tx_valid) |-> o_tx_data == 8'h31)
		else $error("reply does not open with code byte");
	a_reply_after_last: assert property ($rose(o_tx_valid) |-> $past(last_take, 2))
		else $error("reply not two cycles after last byte");
	a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("reply byte moved while stalled");
	a_set_quiet: assert property (o_tx_valid && $past(o_tx_valid) |-> $stable(set_w))
		else $error("settings changed during reply");
	a_change_replied: assert property (!$stable(set_w) |-> ##[0:4] o_tx_valid)
		else $error("settings changed without reply");
	a_busy_no_take: assert property (o_tx_valid |-> !o_rx_ready)
		else $error("command taken during reply");
endmodule : pecr_chk
bind pecr_top pecr_chk u_chk (.i_clk_sys, .i_rstn, .i_rx_valid, .i_rx_last, .o_rx_ready,
	.o_tx_valid, .o_tx_data, .i_tx_ready, .o_in_en, .o_out_en, .o_rec_en, .o_adc_switch,
	.o_adc_ref);

// ==== tb/pecr_host_model.sv ====
// host side model: sends command frames and takes reply bytes
`timescale 1ns/100ps
module pecr_host_model (
	// clock
	input wire logic i_clk_sys,
	// command bytes
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_last,
	input wire logic i_rx_ready,
	// reply bytes
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready
);
	logic [7:0] got[$];
	initial begin
		{o_rx_valid, o_rx_data, o_rx_last} = '0;
	end
	// caller builds code pair, dummy 0x30 and comma layout
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			{o_rx_valid, o_rx_data, o_rx_last} <= {1'b1, b[i], i == b.size() - 1};
			do @(posedge i_clk_sys); while (i_rx_ready !== 1'b1);
		end
		// released line must not keep showing the last byte
		{o_rx_valid, o_rx_last, o_rx_data} <= {2'b00, ~o_rx_data};
	endtask : send
	// random stalls, so replies meet both prompt and slow takers
	always @(posedge i_clk_sys) begin
		if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
		o_tx_ready <= ($urandom % 3) != 0;
	end
endmodule : pecr_host_model

// ==== tb/tb_top.sv ====
// self-checking testbench for the port enable and recovery command handler
`timescale 1ns/100ps
module tb_top;
	import pecr_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
	logic o_pready, o_pslverr, i_rx_valid, i_rx_last, o_rx_ready, o_tx_valid, i_tx_ready, o_irq, er;
	logic [7:0] i_rx_data, o_tx_data, d[$];
	logic [11:0] o_in_en, m_ie;
	logic [9:0] o_out_en, o_rec_en, m_oe, m_rec;
	logic [3:0] o_adc_switch, m_sw;
	logic [1:0] o_adc_ref, m_rf;
	int err_count = 0;
	int comparisons = 0;
	always #12.5 i_clk_sys = ~i_clk_sys;
	pecr_top uut (.i_clk_sys, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
		.o_prdata, .o_pready, .o_pslverr, .i_rx_valid, .i_rx_data, .i_rx_last, .o_rx_ready,
		.o_tx_valid, .o_tx_data, .i_tx_ready, .o_in_en, .o_out_en, .o_rec_en, .o_adc_switch,
		.o_adc_ref, .o_irq);
	pecr_host_model host (.i_clk_sys, .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
		.o_rx_last(i_rx_last), .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid),
		.i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t byte %h exp %h", $time, g, e);
		end
	endtask : chk8
	task automatic chkw(input logic [63:0] g, input logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t value %h exp %h", $time, g, e);
		end
	endtask : chkw
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_clk_sys);
		{i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, wd};
		@(posedge i_clk_sys);
		i_penable <= 1'b1;
		do @(posedge i_clk_sys); while (o_pready !== 1'b1);
		{er, rd} = {o_pslverr, o_prdata};
		{i_psel, i_penable} <= 2'b00;
	endtask : apb
	// one enable or disable byte per bit, comma after every fourth except the final byte
	function automatic void ports(ref logic [7:0] q[$], input logic [11:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			q.push_back(b[i] ? BYTE_ON : BYTE_OFF);
			if (i % 4 == 3 && i != n - 1) q.push_back(BYTE_SEP);
		end
	endfunction : ports
	function automatic void ena_lay(ref logic [7:0] q[$]);
		ports(q, 12'(~m_sw), 4);
		q = {q, BYTE_SEP, 8'h30 + 8'(m_rf), BYTE_SEP};
		ports(q, m_ie, 12);
		q.push_back(BYTE_SEP);
		ports(q, {2'b00, m_oe}, 10);
	endfunction : ena_lay
	// flag 8'hFF means the frame must be dropped with no reply
	task automatic xact(input logic [7:0] code, input logic [7:0] dd[$], input logic [7:0] fl);
		logic [7:0] e[$];
		int n;
		host.got.delete();
		host.send({CODE_HI, code, dd});
		if (fl !== 8'hFF) begin
			e = {CODE_HI, (code < CODE_REC_SET) ? CODE_ENA_RSP : CODE_REC_RSP, fl};
			if (code < CODE_REC_SET) ena_lay(e);
			else ports(e, {2'b00, m_rec}, 10);
		end
		for (n = 0; n < 400 && host.got.size() < e.size(); n++) @(posedge i_clk_sys);
		repeat (8) @(posedge i_clk_sys);
		chkw(host.got.size(), e.size());
		foreach (e[i]) chk8(host.got[i], e[i]);
	endtask : xact
	task automatic chk_set();
		chkw({o_in_en, o_out_en, o_rec_en, o_adc_switch, o_adc_ref}, {m_ie, m_oe, m_rec, m_sw, m_rf});
		apb(1'b0, ADDR_PORT_EN, 32'h0);
		chkw(rd, {m_oe, m_ie});
		apb(1'b0, ADDR_ADC_CFG, 32'h0);
		chkw(rd, {m_rf, m_sw});
		apb(1'b0, ADDR_REC_EN, 32'h0);
		chkw(rd, m_rec);
	endtask : chk_set
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		err_count++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h54E0));
		repeat (4) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		@(posedge i_clk_sys);
		{m_ie, m_oe, m_rec, m_sw, m_rf} = {12'hFFF, 10'h3FF, 10'h3FF, 4'h0, 2'h0};
		chk_set();
		xact(CODE_ENA_QRY, {8'h30}, FLAG_OK);
		xact(CODE_REC_QRY, {8'h30}, FLAG_OK);
		apb(1'b1, ADDR_INT_MASK, 32'h7);
		for (int k = 0; k < 3; k++) begin
			{m_ie, m_oe, m_rec, m_sw} = 36'({$urandom(), $urandom()});
			m_rf = 2'(k);
			d.delete();
			ena_lay(d);
			xact(CODE_ENA_SET, d, FLAG_OK);
			d.delete();
			ports(d, {2'b00, m_rec}, 10);
			xact(CODE_REC_SET, d, FLAG_OK);
			chk_set();
		end
		xact(CODE_ENA_QRY, {8'h30}, FLAG_OK);
		xact(CODE_REC_QRY, {8'h30}, FLAG_OK);
		d[4] = 8'h30;
		xact(CODE_REC_SET, d, FLAG_SETTING_FAILED);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		d.delete();
		ena_lay(d);
		d[5] = 8'h33;
		xact(CODE_ENA_SET, d, FLAG_SETTING_FAILED);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chkw(rd[1], 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h0);
		m_ie = ~m_ie;
		d.delete();
		ena_lay(d);
		m_ie = ~m_ie;
		xact(CODE_ENA_SET, d, FLAG_NOT_SET);
		apb(1'b1, ADDR_CTRL, 32'h1);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		repeat (2) @(posedge i_clk_sys);
		chkw(o_irq, 1'b0);
		xact(8'h37, {8'h30}, 8'hFF);
		chkw(o_irq, 1'b1);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chkw(rd, 32'h4);
		apb(1'b1, ADDR_INT_MASK, 32'h3);
		d.delete();
		ports(d, {2'b00, ~m_rec}, 10);
		void'(d.pop_back());
		xact(CODE_REC_SET, d, 8'hFF);
		chkw(o_irq, 1'b0);
		apb(1'b0, ADDR_INT_STAT, 32'h0);
		chkw(rd, 32'h4);
		apb(1'b0, 8'h1C, 32'h0);
		chkw({er, rd}, {1'b1, 32'h0});
		// dropped frames leave the last reported flag in place
		apb(1'b0, ADDR_STATE, 32'h0);
		chkw({er, rd}, {1'b0, 21'h0, FLAG_NOT_SET, ST_CODE0});
		chk_set();
		end_sim();
	end
endmodule : tb_top
